/* File: logic/p5_pkg.sv */
package p5_pkg;
	// ---------------------------------------------------------------
	// register indices (byte address is four times the index)
	// ---------------------------------------------------------------
	localparam logic [15:0] IDX_DIR = 16'hfeb4; // port_direction
	localparam logic [15:0] IDX_SYS = 16'hff39; // system_control
	localparam logic [15:0] IDX_RDB = 16'hff54; // pin_level_readback
	localparam logic [15:0] IDX_DAT = 16'hff64; // port_output_data
	localparam logic [15:0] IDX_PFC = 16'hffac; // pin_function_control
	localparam int ADDR_W = 18; // bus address width

	// ---------------------------------------------------------------
	// reset values
	// ---------------------------------------------------------------
	localparam logic [3:0] DIR_RST = 4'h0;
	localparam logic [3:0] DAT_RST = 4'h0;
	localparam logic [7:0] PFC_RST = 8'h30;
	localparam logic [7:0] SYS_RST = 8'h01;

	// ---------------------------------------------------------------
	// writable masks
	// ---------------------------------------------------------------
	localparam logic [7:0] PFC_WMASK = 8'hf8; // bits 2..0 read zero
	localparam logic [7:0] SYS_WMASK = 8'hbf; // bit 6 reserved

	// ---------------------------------------------------------------
	// pin_function_control fields
	// ---------------------------------------------------------------
	localparam int PFC_STALL_SEL = 7; // stall_source_select
	localparam int PFC_BREQ_SEL = 6; // bus_req_pin_select
	localparam int PFC_CS_A = 5; // chip_sel_group_a_on
	localparam int PFC_CS_B = 4; // chip_sel_group_b_on
	localparam int PFC_AS_OFF = 3; // addr_strobe_off

	// ---------------------------------------------------------------
	// system_control fields
	// ---------------------------------------------------------------
	localparam int SYS_MODE_HI = 5; // irq_ctrl_mode_hi
	localparam int SYS_MODE_LO = 4; // irq_ctrl_mode_lo
	localparam int SYS_NMI_EDGE = 3; // nonmaskable_edge_pick
	localparam int SYS_LWR_OFF = 2; // low_byte_strobe_off
	localparam int SYS_IRQ_SEL = 1; // ext_irq_pin_group_sel
	localparam int SYS_RAM_ON = 0; // onchip_ram_on

	// ---------------------------------------------------------------
	// bus responses
	// ---------------------------------------------------------------
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* File: logic/p5_port.sv */
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/1ps
// Function
// - four bidirectional pins, four input-only pins
// - direction one drives stored data, zero inputs
// - direction register write-only, reads undefined
// - direction clears on reset, hardware standby
// - output data low nibble; upper ignored
// - output data clears on reset, hardware standby
// - readback register read-only, writes ignored
// - upper readback bits live pins outside sw standby
// - lower readback: data if output, else pin
// - readback frozen in software standby
// - released serial pins revert to port
// - function control resets to 0x30
// - bit 7 picks stall input source
// - bit 6 picks bus-request output pin
// - chip-select, strobe enables; low bits zero
// - system control resets to 0x01
// - system control mode, edge, strobe, ram bits
// - bit 1 routes external interrupts 4-7
// - mode 7 pin 3 lacks stall, request; stall_in_n still follows pin 3 when bit 7 is set
// - routing one feeds interrupts from pins
// - transmit enable overrides pin 0 direction
module p5_port (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// write address channel
	input wire logic [p5_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// write data channel
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// write response channel
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// read address channel
	input wire logic [p5_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// read data channel
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// power state and mode
	input wire logic hw_standby,
	input wire logic sw_standby,
	input wire logic mode7,
	// port pins
	input wire logic [7:0] p5_in,
	output logic [3:0] p5_out,
	output logic [3:0] p5_oe,
	// serial channel 2
	input wire logic tx_on,
	input wire logic serial2_tx_line,
	input wire logic rx_on,
	output logic serial2_rx_line,
	input wire logic serial2_clock_own,
	input wire logic serial2_clock_drive,
	input wire logic serial2_clock_out,
	output logic serial2_clock_in,
	// bus controller
	input wire logic stall_input_on,
	input wire logic bus_req_out_on,
	input wire logic bus_request_out,
	input wire logic p8_6_in,
	output logic stall_in_n,
	output logic bus_req_on_pf2,
	// interrupts and converter trigger
	input wire logic [3:0] p9_irq_in,
	output logic [7:4] ext_irq_n,
	output logic conv_trigger_in,
	// function and system control outputs
	output logic stall_source_select,
	output logic bus_req_pin_select,
	output logic chip_sel_group_a_on,
	output logic chip_sel_group_b_on,
	output logic addr_strobe_off,
	output logic irq_ctrl_mode_hi,
	output logic irq_ctrl_mode_lo,
	output logic nonmaskable_edge_pick,
	output logic low_byte_strobe_off,
	output logic ext_irq_pin_group_sel,
	output logic onchip_ram_on
);

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	// byte address of a register index
	function automatic logic [p5_pkg::ADDR_W-1:0] addr_of(input logic [15:0] idx);
		addr_of = {idx, 2'h0};
	endfunction

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	logic [3:0] dir_r; // port_direction, lower pins only
	logic [3:0] dat_r; // port_output_data, lower pins only
	logic [7:0] pfc_r; // pin_function_control
	logic [7:0] sys_r; // system_control
	logic [7:0] rdb_r; // pin_level_readback snapshot
	logic [7:0] rdb_nxt; // live readback value
	logic aw_held_r; // write address captured
	logic w_held_r; // write data captured
	logic [p5_pkg::ADDR_W-1:0] aw_addr_r;
	logic [7:0] w_byte_r; // low byte of write data
	logic w_lane_r; // low byte lane enabled
	logic bvalid_r;
	logic [1:0] bresp_r;
	logic rvalid_r;
	logic [31:0] rdata_r;
	logic [1:0] rresp_r;
	logic wr_go; // both halves of a write present
	logic ld_dir, ld_dat, ld_pfc, ld_sys; // register write strobes
	logic wr_hit; // write address is mapped, or byte lane 0 disabled
	logic rst_any; // chip reset or hardware standby

	assign rst_any = !aresetn || hw_standby;

	// ---------------------------------------------------------------
	// write channel handshake
	// ---------------------------------------------------------------
	assign s_axi_awready = !aw_held_r && !bvalid_r;
	assign s_axi_wready = !w_held_r && !bvalid_r;
	assign wr_go = aw_held_r && w_held_r && !bvalid_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;

	// address capture, either order with data
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_r <= 1'b0;
			aw_addr_r <= '0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_held_r <= 1'b1;
			aw_addr_r <= s_axi_awaddr;
		end else if (wr_go) begin
			aw_held_r <= 1'b0;
		end
	end

	// data capture, only byte lane 0 matters
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held_r <= 1'b0;
			w_byte_r <= 8'h00;
			w_lane_r <= 1'b0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_held_r <= 1'b1;
			w_byte_r <= s_axi_wdata[7:0];
			w_lane_r <= s_axi_wstrb[0];
		end else if (wr_go) begin
			w_held_r <= 1'b0;
		end
	end

	// write strobes per register, single byte access
	always_comb begin
		ld_dir = wr_go && w_lane_r && aw_addr_r == addr_of(p5_pkg::IDX_DIR);
		ld_dat = wr_go && w_lane_r && aw_addr_r == addr_of(p5_pkg::IDX_DAT);
		ld_pfc = wr_go && w_lane_r && aw_addr_r == addr_of(p5_pkg::IDX_PFC);
		ld_sys = wr_go && w_lane_r && aw_addr_r == addr_of(p5_pkg::IDX_SYS);
		// readback is mapped but writes to it are dropped
		wr_hit = ld_dir || ld_dat || ld_pfc || ld_sys ||
			aw_addr_r == addr_of(p5_pkg::IDX_RDB) || !w_lane_r;
	end

	// write response after both halves
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_r <= 1'b0;
			bresp_r <= p5_pkg::RESP_OKAY;
		end else if (wr_go) begin
			bvalid_r <= 1'b1;
			bresp_r <= wr_hit ? p5_pkg::RESP_OKAY : p5_pkg::RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_r <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// port registers
	// ---------------------------------------------------------------
	// direction, cleared by reset or hardware standby, kept in sw standby
	always_ff @(posedge aclk) begin
		if (rst_any) begin
			dir_r <= p5_pkg::DIR_RST;
		end else if (ld_dir) begin
			dir_r <= w_byte_r[3:0];
		end
	end

	// output data, upper bits ignore writes
	always_ff @(posedge aclk) begin
		if (rst_any) begin
			dat_r <= p5_pkg::DAT_RST;
		end else if (ld_dat) begin
			dat_r <= w_byte_r[3:0];
		end
	end

	// pin function control, low three bits stay zero
	always_ff @(posedge aclk) begin
		if (rst_any) begin
			pfc_r <= p5_pkg::PFC_RST;
		end else if (ld_pfc) begin
			pfc_r <= w_byte_r & p5_pkg::PFC_WMASK;
		end
	end

	// system control, reserved bit 6 stays zero
	always_ff @(posedge aclk) begin
		if (rst_any) begin
			sys_r <= p5_pkg::SYS_RST;
		end else if (ld_sys) begin
			sys_r <= w_byte_r & p5_pkg::SYS_WMASK;
		end
	end

	// ---------------------------------------------------------------
	// pin readback
	// ---------------------------------------------------------------
	// upper pins live; lower pins show data when driven, else the pin
	assign rdb_nxt = {p5_in[7:4], (dir_r & dat_r) | (~dir_r & p5_in[3:0])};

	// snapshot frozen during software standby
	always_ff @(posedge aclk) begin
		if (rst_any) begin
			rdb_r <= {p5_in[7:4], p5_in[3:0]};
		end else if (!sw_standby) begin
			rdb_r <= rdb_nxt;
		end
	end

	// ---------------------------------------------------------------
	// read channel
	// ---------------------------------------------------------------
	assign s_axi_arready = !rvalid_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;

	// decode and register read data
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_r <= 1'b0;
			rdata_r <= 32'h0;
			rresp_r <= p5_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rvalid_r <= 1'b1;
			rresp_r <= p5_pkg::RESP_OKAY;
			case (s_axi_araddr)
				// direction is write-only, reads as zero
				addr_of(p5_pkg::IDX_DIR): rdata_r <= 32'h0;
				// upper data bits read zero
				addr_of(p5_pkg::IDX_DAT): rdata_r <= {28'h0, dat_r};
				addr_of(p5_pkg::IDX_RDB): rdata_r <= {24'h0, rdb_r};
				addr_of(p5_pkg::IDX_PFC): rdata_r <= {24'h0, pfc_r};
				addr_of(p5_pkg::IDX_SYS): rdata_r <= {24'h0, sys_r};
				// unmapped address
				default: begin
					rdata_r <= 32'h0;
					rresp_r <= p5_pkg::RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rready) begin
			rvalid_r <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// pin functions
	// ---------------------------------------------------------------
	logic breq_on_p53; // request output owns pin 3
	logic stall_on_p53; // stall input owns pin 3

	// modes 4 to 6 only; software must pick the pin before enabling
	assign breq_on_p53 = !mode7 && bus_req_out_on && pfc_r[p5_pkg::PFC_BREQ_SEL];
	assign stall_on_p53 = !mode7 && stall_input_on && pfc_r[p5_pkg::PFC_STALL_SEL];

	// pin drivers; serial and bus functions win, then the port registers
	always_comb begin
		// pin 0: transmit line or port
		if (tx_on) begin
			p5_oe[0] = 1'b1;
			p5_out[0] = serial2_tx_line;
		end else begin
			p5_oe[0] = dir_r[0];
			p5_out[0] = dat_r[0];
		end
		// pin 1: receive line is input only
		p5_oe[1] = rx_on ? 1'b0 : dir_r[1];
		p5_out[1] = dat_r[1];
		// pin 2: serial clock or port
		if (serial2_clock_own) begin
			p5_oe[2] = serial2_clock_drive;
			p5_out[2] = serial2_clock_out;
		end else begin
			p5_oe[2] = dir_r[2];
			p5_out[2] = dat_r[2];
		end
		// pin 3: request output, stall input or port
		if (breq_on_p53) begin
			p5_oe[3] = 1'b1;
			p5_out[3] = bus_request_out;
		end else if (stall_on_p53) begin
			p5_oe[3] = 1'b0;
			p5_out[3] = dat_r[3];
		end else begin
			p5_oe[3] = dir_r[3];
			p5_out[3] = dat_r[3];
		end
	end

	// input functions sharing the pins
	assign serial2_rx_line = p5_in[1];
	assign serial2_clock_in = p5_in[2];
	assign conv_trigger_in = p5_in[3];
	// stall source pick
	assign stall_in_n = pfc_r[p5_pkg::PFC_STALL_SEL] ? p5_in[3] : p8_6_in;
	assign bus_req_on_pf2 = !pfc_r[p5_pkg::PFC_BREQ_SEL];
	// interrupts 4..7 from exactly one port
	assign ext_irq_n = sys_r[p5_pkg::SYS_IRQ_SEL] ? p5_in[3:0] : p9_irq_in;

	// ---------------------------------------------------------------
	// control field outputs
	// ---------------------------------------------------------------
	assign stall_source_select = pfc_r[p5_pkg::PFC_STALL_SEL];
	assign bus_req_pin_select = pfc_r[p5_pkg::PFC_BREQ_SEL];
	assign chip_sel_group_a_on = pfc_r[p5_pkg::PFC_CS_A];
	assign chip_sel_group_b_on = pfc_r[p5_pkg::PFC_CS_B];
	assign addr_strobe_off = pfc_r[p5_pkg::PFC_AS_OFF];
	assign irq_ctrl_mode_hi = sys_r[p5_pkg::SYS_MODE_HI];
	assign irq_ctrl_mode_lo = sys_r[p5_pkg::SYS_MODE_LO];
	assign nonmaskable_edge_pick = sys_r[p5_pkg::SYS_NMI_EDGE];
	assign low_byte_strobe_off = sys_r[p5_pkg::SYS_LWR_OFF];
	assign ext_irq_pin_group_sel = sys_r[p5_pkg::SYS_IRQ_SEL];
	assign onchip_ram_on = sys_r[p5_pkg::SYS_RAM_ON];

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_dir_clear: assert property (hw_standby |=> dir_r == 4'h0)
		else $error("direction not cleared by standby");
	a_dat_clear: assert property (hw_standby
		|=> dat_r == 4'h0 && (p5_oe == 4'h0 || tx_on || serial2_clock_own))
		else $error("output data not cleared by standby");
	a_pfc_reset: assert property (hw_standby |=> pfc_r == 8'h30 && !stall_source_select)
		else $error("function control reset value wrong");
	a_sys_reset: assert property (hw_standby |=> onchip_ram_on && !ext_irq_pin_group_sel)
		else $error("system control reset value wrong");
	a_upper_live: assert property (!sw_standby && !hw_standby |=> rdb_r[7:4] == $past(p5_in[7:4]))
		else $error("upper readback not live");
	a_input_read: assert property (!hw_standby && !sw_standby && dir_r == 4'h0 |=> rdb_r[3:0] == $past(p5_in[3:0]))
		else $error("input pin readback wrong");
	a_standby_hold: assert property ((sw_standby && !hw_standby) [*2] |-> $stable(rdb_r))
		else $error("readback changed in software standby");
	a_stall_src: assert property (stall_in_n == (stall_source_select ? p5_in[3] : p8_6_in))
		else $error("stall source wrong");
	a_tx_pin: assert property (tx_on |-> p5_oe[0] && p5_out[0] == serial2_tx_line)
		else $error("transmit line not on pin 0");
	a_irq_route: assert property (ext_irq_pin_group_sel |-> ext_irq_n == p5_in[3:0])
		else $error("interrupt routing wrong");
	a_mode7_pin3: assert property (mode7 |-> p5_oe[3] == dir_r[3])
		else $error("pin 3 special function in mode 7");
	a_dir_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == addr_of(p5_pkg::IDX_DIR)
		|=> s_axi_rvalid && s_axi_rdata == 32'h0)
		else $error("direction register readable");
	a_write_resp: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|-> ##[1:2] s_axi_bvalid)
		else $error("write response late");

	c_pin_out: cover property (ld_dir ##1 ld_dat ##[1:4] p5_oe[0]);
	c_breq_pin: cover property (breq_on_p53 && p5_oe[3]);
	c_standby: cover property (sw_standby [*3]);
	c_unmapped: cover property (s_axi_rvalid && s_axi_rresp == p5_pkg::RESP_SLVERR);

endmodule // p5_port

/* File: tb/p5_board.sv */
`timescale 1ns/1ps
// ----------------------------------------
// board model: drives the pins, pull-ups on idle lower pins
// ----------------------------------------
module p5_board (
	// from the port
	input wire logic [3:0] p5_out,
	input wire logic [3:0] p5_oe,
	// board drive
	input wire logic [7:0] board_lvl,
	input wire logic [3:0] board_oe,
	// resolved pin levels
	output logic [7:0] p5_in
);
	// upper pins input-only, always board driven; lower: port wins, else board, else pull-up
	always_comb begin
		p5_in[7:4] = board_lvl[7:4];
		for (int i = 0; i < 4; i++) begin
			p5_in[i] = p5_oe[i] ? p5_out[i] : (board_oe[i] ? board_lvl[i] : 1'b1);
		end
	end
endmodule // p5_board

/* File: tb/tb.sv */
`timescale 1ns/1ps
module tb;
	// ----------------------------------------
	// clock, reset, counters
	// ----------------------------------------
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	int err_total = 0;
	int n_compared = 0;
	int cyc = 0;
	always #5 aclk = ~aclk;
	// byte addresses, four times the index
	localparam logic [17:0] A_DIR = {p5_pkg::IDX_DIR, 2'b00};
	localparam logic [17:0] A_SYS = {p5_pkg::IDX_SYS, 2'b00};
	localparam logic [17:0] A_RDB = {p5_pkg::IDX_RDB, 2'b00};
	localparam logic [17:0] A_DAT = {p5_pkg::IDX_DAT, 2'b00};
	localparam logic [17:0] A_PFC = {p5_pkg::IDX_PFC, 2'b00};
	// bus
	logic [17:0] s_axi_awaddr = '0;
	logic s_axi_awvalid = 1'b0;
	logic s_axi_awready;
	logic [31:0] s_axi_wdata = '0;
	logic [3:0] s_axi_wstrb = 4'h0;
	logic s_axi_wvalid = 1'b0;
	logic s_axi_wready;
	logic [1:0] s_axi_bresp;
	logic s_axi_bvalid;
	logic s_axi_bready = 1'b0;
	logic [17:0] s_axi_araddr = '0;
	logic s_axi_arvalid = 1'b0;
	logic s_axi_arready;
	logic [31:0] s_axi_rdata;
	logic [1:0] s_axi_rresp;
	logic s_axi_rvalid;
	logic s_axi_rready = 1'b0;
	// side inputs
	logic hw_standby = 1'b0;
	logic sw_standby = 1'b0;
	logic mode7 = 1'b0;
	logic tx_on = 1'b0;
	logic serial2_tx_line = 1'b1;
	logic rx_on = 1'b0;
	logic serial2_clock_own = 1'b0;
	logic serial2_clock_drive = 1'b0;
	logic serial2_clock_out = 1'b0;
	logic stall_input_on = 1'b0;
	logic bus_req_out_on = 1'b0;
	logic bus_request_out = 1'b1;
	logic p8_6_in = 1'b1;
	logic [3:0] p9_irq_in = 4'h0;
	logic [7:0] board_lvl = 8'h00;
	logic [3:0] board_oe = 4'h0;
	// pins and outputs
	logic [7:0] p5_in;
	logic [3:0] p5_out;
	logic [3:0] p5_oe;
	logic stall_in_n;
	logic bus_req_on_pf2;
	logic [7:4] ext_irq_n;
	logic serial2_rx_line, serial2_clock_in, conv_trigger_in;
	logic stall_source_select, bus_req_pin_select, chip_sel_group_a_on, chip_sel_group_b_on, addr_strobe_off;
	logic irq_ctrl_mode_hi, irq_ctrl_mode_lo, nonmaskable_edge_pick, low_byte_strobe_off;
	logic ext_irq_pin_group_sel, onchip_ram_on;

	p5_port dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .hw_standby, .sw_standby, .mode7,
		.p5_in, .p5_out, .p5_oe, .tx_on, .serial2_tx_line, .rx_on, .serial2_rx_line,
		.serial2_clock_own, .serial2_clock_drive, .serial2_clock_out, .serial2_clock_in,
		.stall_input_on, .bus_req_out_on, .bus_request_out, .p8_6_in, .stall_in_n, .bus_req_on_pf2, .p9_irq_in,
		.ext_irq_n, .conv_trigger_in, .stall_source_select, .bus_req_pin_select, .chip_sel_group_a_on,
		.chip_sel_group_b_on, .addr_strobe_off, .irq_ctrl_mode_hi, .irq_ctrl_mode_lo, .nonmaskable_edge_pick,
		.low_byte_strobe_off, .ext_irq_pin_group_sel, .onchip_ram_on);
	p5_board board (.p5_out, .p5_oe, .board_lvl, .board_oe, .p5_in);

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		n_compared++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask
	// let pin changes and the readback snapshot land, check at a negedge
	task automatic settle();
		repeat (3) @(posedge aclk);
		@(negedge aclk);
	endtask
	// write one byte, hold each channel until its ready, check the response
	task automatic wr(input logic [17:0] a, input logic [7:0] d, input logic [1:0] er);
		logic aw_go, w_go, b_go;
		logic [1:0] rsp;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, d};
		s_axi_wstrb <= 4'h1;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(negedge aclk);
			aw_go = s_axi_awvalid && s_axi_awready;
			w_go = s_axi_wvalid && s_axi_wready;
			b_go = s_axi_bvalid;
			rsp = s_axi_bresp;
			@(posedge aclk);
			if (aw_go) s_axi_awvalid <= 1'b0;
			if (w_go) s_axi_wvalid <= 1'b0;
		end while (!b_go);
		s_axi_bready <= 1'b0;
		chk({30'h0, rsp}, {30'h0, er}, "bresp");
	endtask
	// read one word and compare data and response
	task automatic rd(input logic [17:0] a, input logic [7:0] exp, input logic [1:0] er);
		logic ar_go, r_go;
		logic [31:0] dat;
		logic [1:0] rsp;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(negedge aclk);
			ar_go = s_axi_arvalid && s_axi_arready;
			r_go = s_axi_rvalid;
			dat = s_axi_rdata;
			rsp = s_axi_rresp;
			@(posedge aclk);
			if (ar_go) s_axi_arvalid <= 1'b0;
		end while (!r_go);
		s_axi_rready <= 1'b0;
		chk(dat, {24'h0, exp}, "rdata");
		chk({30'h0, rsp}, {30'h0, er}, "rresp");
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset();
		rd(A_PFC, 8'h30, p5_pkg::RESP_OKAY);
		rd(A_SYS, 8'h01, p5_pkg::RESP_OKAY);
		rd(A_DAT, 8'h00, p5_pkg::RESP_OKAY);
		chk({28'h0, p5_oe}, 32'h0, "oe after reset");
	endtask
	task automatic t_data();
		wr(A_DAT, 8'hff, p5_pkg::RESP_OKAY);
		rd(A_DAT, 8'h0f, p5_pkg::RESP_OKAY);
		wr(A_DIR, 8'h0f, p5_pkg::RESP_OKAY);
		board_lvl <= 8'ha0;
		settle();
		chk({24'h0, p5_oe, p5_out}, 32'hff, "drive all");
		rd(A_RDB, 8'haf, p5_pkg::RESP_OKAY);
		rd(A_DIR, 8'h00, p5_pkg::RESP_OKAY);
		wr(A_DAT, 8'h0a, p5_pkg::RESP_OKAY);
		wr(A_DIR, 8'h05, p5_pkg::RESP_OKAY);
		board_lvl <= 8'ha8;
		board_oe <= 4'hf;
		settle();
		rd(A_RDB, 8'ha8, p5_pkg::RESP_OKAY);
		wr(A_RDB, 8'hff, p5_pkg::RESP_OKAY);
		rd(A_DAT, 8'h0a, p5_pkg::RESP_OKAY);
	endtask
	task automatic t_stby();
		@(posedge aclk);
		sw_standby <= 1'b1;
		board_lvl <= 8'h58;
		settle();
		rd(A_RDB, 8'ha8, p5_pkg::RESP_OKAY);
		sw_standby <= 1'b0;
		chk({28'h0, p5_oe}, 32'h5, "dir kept");
		rd(A_DAT, 8'h0a, p5_pkg::RESP_OKAY);
		hw_standby <= 1'b1;
		settle();
		@(posedge aclk);
		hw_standby <= 1'b0;
		chk({28'h0, p5_oe}, 32'h0, "dir cleared");
		rd(A_DAT, 8'h00, p5_pkg::RESP_OKAY);
		rd(A_PFC, 8'h30, p5_pkg::RESP_OKAY);
		rd(A_SYS, 8'h01, p5_pkg::RESP_OKAY);
		rd(A_RDB, 8'h58, p5_pkg::RESP_OKAY);
	endtask
	task automatic t_func();
		wr(A_PFC, 8'hff, p5_pkg::RESP_OKAY);
		rd(A_PFC, 8'hf8, p5_pkg::RESP_OKAY);
		chk({27'h0, stall_source_select, bus_req_pin_select, chip_sel_group_a_on, chip_sel_group_b_on,
			addr_strobe_off}, 32'h1f, "pfc fields");
		board_lvl <= 8'h00;
		p8_6_in <= 1'b1;
		stall_input_on <= 1'b1;
		settle();
		chk({31'h0, stall_in_n}, 32'h0, "stall from pin");
		chk({31'h0, bus_req_on_pf2}, 32'h0, "breq off pf2");
		@(posedge aclk);
		stall_input_on <= 1'b0;
		board_oe <= 4'h0;
		bus_request_out <= 1'b0;
		bus_req_out_on <= 1'b1;
		settle();
		chk({30'h0, p5_oe[3], p5_out[3]}, 32'h2, "breq on pin");
		@(posedge aclk);
		mode7 <= 1'b1;
		settle();
		chk({31'h0, p5_oe[3]}, 32'h0, "mode7 pin3");
		@(posedge aclk);
		mode7 <= 1'b0;
		bus_req_out_on <= 1'b0;
		wr(A_PFC, 8'h30, p5_pkg::RESP_OKAY);
		settle();
		chk({30'h0, stall_in_n, bus_req_on_pf2}, 32'h3, "default routes");
	endtask
	task automatic t_sys();
		wr(A_SYS, 8'hff, p5_pkg::RESP_OKAY);
		rd(A_SYS, 8'hbf, p5_pkg::RESP_OKAY);
		chk({26'h0, irq_ctrl_mode_hi, irq_ctrl_mode_lo, nonmaskable_edge_pick, low_byte_strobe_off,
			ext_irq_pin_group_sel, onchip_ram_on}, 32'h3f, "sys fields");
		board_lvl <= 8'ha5;
		board_oe <= 4'hf;
		p9_irq_in <= 4'ha;
		settle();
		chk({28'h0, ext_irq_n}, 32'h5, "irq from port");
		wr(A_SYS, 8'h01, p5_pkg::RESP_OKAY);
		settle();
		chk({28'h0, ext_irq_n}, 32'ha, "irq from other");
	endtask
	task automatic t_serial();
		@(posedge aclk);
		board_oe <= 4'h0;
		serial2_tx_line <= 1'b0;
		tx_on <= 1'b1;
		settle();
		chk({30'h0, p5_oe[0], p5_out[0]}, 32'h2, "tx drives pin0");
		@(posedge aclk);
		tx_on <= 1'b0;
		wr(A_DIR, 8'h01, p5_pkg::RESP_OKAY);
		wr(A_DAT, 8'h01, p5_pkg::RESP_OKAY);
		settle();
		chk({30'h0, p5_oe[0], p5_out[0]}, 32'h3, "pin0 back to port");
		// pins 1 and 2 set as outputs, then taken over by receive line and serial clock
		wr(A_DIR, 8'h06, p5_pkg::RESP_OKAY);
		rx_on <= 1'b1;
		serial2_clock_own <= 1'b1;
		serial2_clock_drive <= 1'b1;
		serial2_clock_out <= 1'b1;
		board_lvl <= 8'h02;
		board_oe <= 4'h2;
		settle();
		chk({28'h0, p5_oe}, 32'h4, "serial pin enables");
		chk({29'h0, serial2_rx_line, serial2_clock_in, conv_trigger_in}, 32'h7, "serial inputs");
		@(posedge aclk);
		rx_on <= 1'b0;
		serial2_clock_own <= 1'b0;
		settle();
		chk({28'h0, p5_oe}, 32'h6, "serial released");
		wr(18'h00000, 8'h12, p5_pkg::RESP_SLVERR);
		rd(18'h00000, 8'h00, p5_pkg::RESP_SLVERR);
	endtask

	// ----------------------------------------
	// verdict, timeout, main sequence
	// ----------------------------------------
	task automatic test_done();
		if (err_total == 0 && n_compared > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_total++;
			$display("[ERR] %0t timeout", $time);
			test_done();
		end
	end
	initial begin
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset();
		t_data();
		t_stby();
		t_func();
		t_sys();
		t_serial();
		test_done();
	end
endmodule // tb
